// file: timer_pkg.sv
/*
 * Shared constants for the system timer: bus widths, register selects, control field positions,
 * reset values and the small enumerations used by the timer core and its clock generator.
 * Assumes it is compiled before every other file of the timer.
 */
`default_nettype none

package timer_pkg;

   // ==========================================================================
   // Widths
   localparam int DATA_W = 8;
   localparam int RS_W = 5;
   localparam int PORTC_W = 8;
   localparam int COUNT_W = 3 * DATA_W;
   localparam int PRESCALE_W_DEF = 5;
   localparam int PRESCALE_W_MIN = 3;

   // ==========================================================================
   // Register selects
   localparam logic [RS_W-1:0] RS_PORTC_DATA = 5'h0C;
   localparam logic [RS_W-1:0] RS_TIMER_CONTROL = 5'h10;
   localparam logic [RS_W-1:0] RS_TIMER_VECTOR = 5'h11;
   localparam logic [RS_W-1:0] RS_PRELOAD_HIGH = 5'h13;
   localparam logic [RS_W-1:0] RS_PRELOAD_MID = 5'h14;
   localparam logic [RS_W-1:0] RS_PRELOAD_LOW = 5'h15;
   localparam logic [RS_W-1:0] RS_COUNT_HIGH = 5'h17;
   localparam logic [RS_W-1:0] RS_COUNT_MID = 5'h18;
   localparam logic [RS_W-1:0] RS_COUNT_LOW = 5'h19;
   localparam logic [RS_W-1:0] RS_TIMER_STATUS = 5'h1A;

   // ==========================================================================
   // Field positions
   localparam int CTRL_OUT_MODE_LSB = 6;
   localparam int CTRL_ACK_ENABLE_BIT = 5;
   localparam int CTRL_ZERO_ROLL_BIT = 4;
   localparam int CTRL_CLOCK_LSB = 1;
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int STATUS_ZERO_BIT = 0;
   localparam int PORTC_TIMER_OUT_BIT = 3;
   localparam int BYTE_HIGH_LSB = 16;
   localparam int BYTE_MID_LSB = 8;
   localparam int BYTE_LOW_LSB = 0;

   // ==========================================================================
   // Reset and special values
   localparam logic [DATA_W-1:0] CONTROL_RESET = 8'h00;
   localparam logic [DATA_W-1:0] VECTOR_RESET = 8'h0F;
   localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
   localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 24'h000000;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h000001;
   localparam logic [COUNT_W-1:0] COUNT_ALL_ONES = 24'hFFFFFF;

   // ==========================================================================
   // Enumerations
   typedef enum logic [1:0] {
      CLK_SYSTEM = 2'h0,
      CLK_SYSTEM_GATED = 2'h1,
      CLK_INPUT_PRESCALED = 2'h2,
      CLK_INPUT_DIRECT = 2'h3
   } clock_sel_e;

   typedef enum logic [1:0] {
      OUT_PORT = 2'h0,
      OUT_SQUARE = 2'h1,
      OUT_IRQ = 2'h2,
      OUT_IRQ_ALT = 2'h3
   } out_mode_e;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'h0,
      BUS_ACK = 2'h1,
      BUS_VECTOR = 2'h2
   } bus_state_e;

endpackage

`default_nettype wire

// file: timer_tick_if.sv
/*
 * Carrier between the timer core and its prescaler: run state, clock source and counter tick.
 * Assumes the core drives every signal except the tick, which the clock generator drives.
 */
`timescale 1ns/100ps
`default_nettype none

interface timer_tick_if;
   logic run;
   logic ext_source;
   logic direct;
   logic input_rise;
   logic tick;

   modport gen (input run, input ext_source, input direct, input input_rise, output tick);
   modport core (output run, output ext_source, output direct, output input_rise, input tick);
endinterface

`default_nettype wire

// file: timer_clock_gen.sv
/*
 * Prescaler and counter clock generator of the system timer.
 * Assumes the core presents a run state and a one-cycle rising edge of the timer input pin.
 */
`timescale 1ns/100ps
`default_nettype none

module timer_clock_gen #(
   parameter int PRESCALE_W = timer_pkg::PRESCALE_W_DEF
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rstn_in,
   // Tick carrier
   timer_tick_if.gen tick_bus
);
   import timer_pkg::*;

   // ==========================================================================
   // State
   localparam logic [PRESCALE_W-1:0] PRESCALE_ALL_ONES = {PRESCALE_W{1'b1}};
   localparam logic [PRESCALE_W-1:0] PRESCALE_ZERO = {PRESCALE_W{1'b0}};
   localparam logic [PRESCALE_W-1:0] PRESCALE_STEP = {{(PRESCALE_W-1){1'b0}}, 1'b1};

   typedef struct packed {
      logic [PRESCALE_W-1:0] prescale;
   } gen_state_s;

   gen_state_s s_reg;
   gen_state_s s_next;
   logic step;

   if (PRESCALE_W < PRESCALE_W_MIN) begin : g_check
      $error("Prescaler too narrow for the counter input rate.");
   end

   // ==========================================================================
   // Prescaler
   always_comb begin
      s_next = s_reg;
      step = tick_bus.ext_source ? tick_bus.input_rise : 1'b1;
      tick_bus.tick = 1'b0;
      if (!tick_bus.run) begin
         s_next.prescale = PRESCALE_ALL_ONES;
      end else if (tick_bus.direct) begin
         tick_bus.tick = tick_bus.input_rise;
      end else if (step) begin
         s_next.prescale = s_reg.prescale - PRESCALE_STEP;
         tick_bus.tick = (s_reg.prescale == PRESCALE_ZERO);
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         s_reg <= '{prescale: PRESCALE_ALL_ONES};
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);

   a_prescale_halt_forced: assert property (!tick_bus.run |=> s_reg.prescale == PRESCALE_ALL_ONES)
      else $error("Prescaler not forced to all ones while halted.");
   a_tick_on_rollover: assert property (tick_bus.tick && !tick_bus.direct |=> s_reg.prescale == PRESCALE_ALL_ONES)
      else $error("Counter tick without prescaler rollover.");
   a_direct_input_tick: assert property (tick_bus.run && tick_bus.direct && tick_bus.input_rise |-> tick_bus.tick)
      else $error("Timer input edge not passed to the counter.");
   a_halt_no_tick: assert property (!tick_bus.run |-> !tick_bus.tick)
      else $error("Counter tick while halted.");

endmodule

`default_nettype wire

// file: timer_application_modes.sv
/*
 * System timer core: 24-bit down counter with reload or rollover, zero detect flag, square wave
 * and interrupt request output, watchdog gating, interrupt acknowledge response and register bus.
 * Assumes a synchronous host bus with active-low chip select and data transfer acknowledge,
 * and timer pins that are already synchronous to clock_in.
 */
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Count one to zero sets flag, toggles output.
// - Next counter clock reloads preload, then decrements.
// - Square wave runs regardless of flag clearing.
// - Output level readable at port data address.
// - After reset, output pin is port input.
// - Output high before square wave enabled.
// - Acknowledge ignored unless interrupt request asserted.
// - Asserted request: vector on bus, acknowledge.
// - Zero roll control: counter wraps, no reload.
// - Flag latches until host clears it or timer halts.
// - External clock selection counts timer input.
// - Input edges while halted are ignored.
// - Watchdog: input level selects run or halt.
// - Watchdog input high loads preload, counts.
// - Early input fall: no flag, output stays negated.
// - Zero while high: flag, output, rollover.
// - Watchdog fall clears flag, output, stops.
// - Status write bit zero clears flag.
// - Halt keeps count, presets prescaler, clears flag.
// - First prescaler rollover loads, later ones count.
module timer_application_modes #(
   parameter int PRESCALE_W = timer_pkg::PRESCALE_W_DEF
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rstn_in,
   // Host bus
   input wire logic cs_n_in,
   input wire logic rw_in,
   input wire logic [timer_pkg::RS_W-1:0] rs_in,
   input wire logic [timer_pkg::DATA_W-1:0] data_in,
   output logic [timer_pkg::DATA_W-1:0] data_out,
   output logic data_oe_out,
   output logic bus_transfer_ack_n_out,
   // Timer pins
   input wire logic timer_input_pin_in,
   input wire logic timer_irq_ack_pin_n_in,
   output logic timer_output_pin_out,
   output logic timer_output_pin_oe_out,
   // Port C pin levels
   input wire logic [timer_pkg::PORTC_W-1:0] portc_in
);
   import timer_pkg::*;

   // ==========================================================================
   // State
   typedef struct packed {
      bus_state_e bus;
      logic [DATA_W-1:0] data;
      logic data_oe;
      logic ack_n;
      logic [DATA_W-1:0] control;
      logic [DATA_W-1:0] vector;
      logic [COUNT_W-1:0] preload;
      logic [COUNT_W-1:0] count;
      logic zero_detect_flag;
      logic square;
      logic load_pending;
      logic input_prev;
      logic out_level;
      logic out_oe;
   } state_s;

   localparam state_s STATE_RESET = '{
      bus: BUS_IDLE,
      data: DATA_RESET,
      data_oe: 1'b0,
      ack_n: 1'b1,
      control: CONTROL_RESET,
      vector: VECTOR_RESET,
      preload: COUNT_RESET,
      count: COUNT_RESET,
      zero_detect_flag: 1'b0,
      square: 1'b1,
      load_pending: 1'b1,
      input_prev: 1'b0,
      out_level: 1'b0,
      out_oe: 1'b0
   };

   state_s s_reg;
   state_s s_next;
   logic run;
   logic input_rise;
   logic enabled;
   logic zero_step;
   logic ack_request;
   clock_sel_e clock_sel;
   out_mode_e out_mode;

   timer_tick_if tick_bus();

   // ==========================================================================
   // Clock generator
   timer_clock_gen #(
      .PRESCALE_W(PRESCALE_W)
   ) u_clock_gen (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .tick_bus(tick_bus.gen)
   );

   assign tick_bus.run = run;
   assign tick_bus.ext_source = (clock_sel == CLK_INPUT_PRESCALED);
   assign tick_bus.direct = (clock_sel == CLK_INPUT_DIRECT);
   assign tick_bus.input_rise = input_rise;

   // ==========================================================================
   // Register read path
   function automatic logic [DATA_W-1:0] read_value(input logic [RS_W-1:0] sel, input state_s st,
                                                    input logic [PORTC_W-1:0] portc);
      logic [DATA_W-1:0] v;
      v = DATA_RESET;
      case (sel)
         RS_PORTC_DATA: begin
            v = portc;
            if (out_mode_e'(st.control[CTRL_OUT_MODE_LSB +: 2]) != OUT_PORT) begin
               v[PORTC_TIMER_OUT_BIT] = st.out_level;
            end
         end
         RS_TIMER_CONTROL: v = st.control;
         RS_TIMER_VECTOR: v = st.vector;
         RS_PRELOAD_HIGH: v = st.preload[BYTE_HIGH_LSB +: DATA_W];
         RS_PRELOAD_MID: v = st.preload[BYTE_MID_LSB +: DATA_W];
         RS_PRELOAD_LOW: v = st.preload[BYTE_LOW_LSB +: DATA_W];
         RS_COUNT_HIGH: v = st.count[BYTE_HIGH_LSB +: DATA_W];
         RS_COUNT_MID: v = st.count[BYTE_MID_LSB +: DATA_W];
         RS_COUNT_LOW: v = st.count[BYTE_LOW_LSB +: DATA_W];
         RS_TIMER_STATUS: v[STATUS_ZERO_BIT] = st.zero_detect_flag;
         default: v = DATA_RESET;
      endcase
      return v;
   endfunction

   // ==========================================================================
   // Next state
   always_comb begin
      s_next = s_reg;
      clock_sel = clock_sel_e'(s_reg.control[CTRL_CLOCK_LSB +: 2]);
      out_mode = out_mode_e'(s_reg.control[CTRL_OUT_MODE_LSB +: 2]);
      enabled = s_reg.control[CTRL_ENABLE_BIT];
      run = enabled && ((clock_sel != CLK_SYSTEM_GATED) || timer_input_pin_in);
      input_rise = timer_input_pin_in && !s_reg.input_prev;
      zero_step = run && tick_bus.tick && !s_reg.load_pending && (s_reg.count == COUNT_ONE);
      ack_request = out_mode[1] && s_reg.control[CTRL_ACK_ENABLE_BIT] && s_reg.zero_detect_flag;
      s_next.input_prev = timer_input_pin_in;

      // Host bus and interrupt acknowledge.
      case (s_reg.bus)
         BUS_IDLE: begin
            if (!cs_n_in) begin
               s_next.bus = BUS_ACK;
               s_next.ack_n = 1'b0;
               if (rw_in) begin
                  s_next.data = read_value(rs_in, s_reg, portc_in);
                  s_next.data_oe = 1'b1;
               end else begin
                  case (rs_in)
                     RS_TIMER_CONTROL: s_next.control = data_in;
                     RS_TIMER_VECTOR: s_next.vector = data_in;
                     RS_PRELOAD_HIGH: s_next.preload[BYTE_HIGH_LSB +: DATA_W] = data_in;
                     RS_PRELOAD_MID: s_next.preload[BYTE_MID_LSB +: DATA_W] = data_in;
                     RS_PRELOAD_LOW: s_next.preload[BYTE_LOW_LSB +: DATA_W] = data_in;
                     RS_TIMER_STATUS: begin
                        if (data_in[STATUS_ZERO_BIT]) begin
                           s_next.zero_detect_flag = 1'b0;
                        end
                     end
                     default: s_next.data_oe = 1'b0;
                  endcase
               end
            end else if (!timer_irq_ack_pin_n_in && ack_request) begin
               s_next.bus = BUS_VECTOR;
               s_next.data = s_reg.vector;
               s_next.data_oe = 1'b1;
               s_next.ack_n = 1'b0;
            end
         end
         BUS_ACK: begin
            if (cs_n_in) begin
               s_next.bus = BUS_IDLE;
               s_next.ack_n = 1'b1;
               s_next.data_oe = 1'b0;
            end
         end
         BUS_VECTOR: begin
            if (timer_irq_ack_pin_n_in) begin
               s_next.bus = BUS_IDLE;
               s_next.ack_n = 1'b1;
               s_next.data_oe = 1'b0;
            end
         end
         default: begin
            s_next.bus = BUS_IDLE;
            s_next.ack_n = 1'b1;
            s_next.data_oe = 1'b0;
         end
      endcase

      // Counter, applied after the status write so that a detection wins over a clear.
      if (!run) begin
         s_next.zero_detect_flag = 1'b0;
         s_next.load_pending = 1'b1;
      end else if (tick_bus.tick) begin
         if (s_reg.load_pending) begin
            s_next.count = s_reg.preload;
            s_next.load_pending = 1'b0;
         end else if ((s_reg.count == COUNT_ZERO) && !s_reg.control[CTRL_ZERO_ROLL_BIT]) begin
            s_next.count = s_reg.preload;
         end else begin
            s_next.count = s_reg.count - COUNT_ONE;
         end
         if (zero_step) begin
            s_next.zero_detect_flag = 1'b1;
            s_next.square = !s_reg.square;
         end
      end
      if (!enabled) begin
         s_next.square = 1'b1;
      end

      // Timer output pin, from the settled next state.
      case (out_mode_e'(s_next.control[CTRL_OUT_MODE_LSB +: 2]))
         OUT_PORT: begin
            s_next.out_level = 1'b0;
            s_next.out_oe = 1'b0;
         end
         OUT_SQUARE: begin
            s_next.out_level = s_next.square;
            s_next.out_oe = 1'b1;
         end
         default: begin
            s_next.out_level = !s_next.zero_detect_flag;
            s_next.out_oe = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         s_reg <= STATE_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign data_out = s_reg.data;
   assign data_oe_out = s_reg.data_oe;
   assign bus_transfer_ack_n_out = s_reg.ack_n;
   assign timer_output_pin_out = s_reg.out_level;
   assign timer_output_pin_oe_out = s_reg.out_oe;

   // ==========================================================================
   // Checks
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);

   sequence s_count_step;
      run && tick_bus.tick && !s_reg.load_pending;
   endsequence

   sequence s_idle_ack;
      s_reg.bus == BUS_IDLE && cs_n_in && !timer_irq_ack_pin_n_in;
   endsequence

   sequence s_square_disabled;
      (!enabled && out_mode == OUT_SQUARE && cs_n_in)[*2];
   endsequence

   a_zero_sets_flag: assert property (s_count_step ##0 s_reg.count == COUNT_ONE |=>
         s_reg.zero_detect_flag && s_reg.count == COUNT_ZERO)
      else $error("Zero detect flag not set on step from one to zero.");
   a_square_toggles: assert property (s_count_step ##0 s_reg.count == COUNT_ONE ##0 enabled |=>
         s_reg.square != $past(s_reg.square))
      else $error("Square wave did not toggle at zero.");
   a_zero_reloads: assert property (s_count_step ##0 s_reg.count == COUNT_ZERO
         ##0 !s_reg.control[CTRL_ZERO_ROLL_BIT] |=> s_reg.count == $past(s_reg.preload))
      else $error("Counter not reloaded after zero.");
   a_zero_rolls_over: assert property (s_count_step ##0 s_reg.count == COUNT_ZERO
         ##0 s_reg.control[CTRL_ZERO_ROLL_BIT] |=> s_reg.count == COUNT_ALL_ONES)
      else $error("Counter did not roll over.");
   a_count_decrements: assert property (s_count_step ##0 s_reg.count != COUNT_ZERO |=>
         s_reg.count == $past(s_reg.count) - COUNT_ONE)
      else $error("Counter did not decrement by one.");
   a_first_tick_loads: assert property (run && tick_bus.tick && s_reg.load_pending |=>
         s_reg.count == $past(s_reg.preload) && !s_reg.load_pending)
      else $error("First counter clock did not load the preload value.");
   a_halt_holds_count: assert property (!run |=> s_reg.count == $past(s_reg.count)
         && !s_reg.zero_detect_flag)
      else $error("Halt changed the counter or left the flag set.");
   a_watchdog_fall_clears: assert property (enabled && clock_sel == CLK_SYSTEM_GATED && s_reg.input_prev
         && !timer_input_pin_in && cs_n_in |=> !s_reg.zero_detect_flag ##1 !s_reg.zero_detect_flag)
      else $error("Watchdog input fall did not clear the flag.");
   a_out_high_disabled: assert property (s_square_disabled |-> timer_output_pin_out && timer_output_pin_oe_out)
      else $error("Square wave output not high while disabled.");
   a_vector_on_ack: assert property (s_idle_ack ##0 ack_request |=>
         data_out == $past(s_reg.vector) && data_oe_out && !bus_transfer_ack_n_out)
      else $error("Vector not presented on asserted acknowledge.");
   a_ack_ignored: assert property (s_idle_ack ##0 !ack_request |=> bus_transfer_ack_n_out && !data_oe_out)
      else $error("Acknowledge answered without an interrupt request.");
   a_status_clears: assert property (s_reg.bus == BUS_IDLE && !cs_n_in && !rw_in && rs_in == RS_TIMER_STATUS
         && data_in[STATUS_ZERO_BIT] && !zero_step |=> !s_reg.zero_detect_flag)
      else $error("Status write did not clear the flag.");
   a_port_reads_output: assert property (s_reg.bus == BUS_IDLE && !cs_n_in && rw_in && rs_in == RS_PORTC_DATA
         && out_mode != OUT_PORT |=> data_out[PORTC_TIMER_OUT_BIT] == $past(s_reg.out_level))
      else $error("Port read does not show the timer output level.");
   a_port_after_reset: assert property ($rose(rstn_in) |-> !timer_output_pin_oe_out)
      else $error("Timer output driven after reset.");

endmodule

`default_nettype wire

// file: host_bus_model.sv
/* Host processor model: read and write cycles on the timer's register bus.
   Assumes a clocked bus with active-low select and a registered active-low acknowledge. */
`timescale 1ns/100ps
`default_nettype none
module host_bus_model (
   // Clock
   input wire logic clock_in,
   // Answer from the timer
   input wire logic ack_n_in,
   input wire logic [7:0] rdata_in,
   // Request to the timer
   output logic cs_n_out,
   output logic rw_out,
   output logic [4:0] rs_out,
   output logic [7:0] wdata_out
);
   int timeouts = 0;
   initial begin
      cs_n_out = 1'b1;
      rw_out = 1'b1;
      rs_out = 5'h00;
      wdata_out = 8'h00;
   end
   // ==========================================
   // One access; request held until acknowledge is sampled low.
   task automatic access(input logic rd, input logic [4:0] a, input logic [7:0] wd, output logic [7:0] q);
      int n;
      @(posedge clock_in);
      cs_n_out <= 1'b0;
      rw_out <= rd;
      rs_out <= a;
      wdata_out <= wd;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (ack_n_in !== 1'b0 && n < 20);
      if (ack_n_in !== 1'b0) begin
         timeouts++;
      end
      q = rdata_in;
      cs_n_out <= 1'b1;
      rs_out <= ~a;
      wdata_out <= ~wd;
      n = 0;
      do begin
         @(posedge clock_in);
         n++;
      end while (ack_n_in !== 1'b1 && n < 20);
      if (ack_n_in !== 1'b1) begin
         timeouts++;
      end
   endtask
endmodule
`default_nettype wire

// file: timer_application_modes_test.sv
/* Self-checking bench of the system timer: register, square wave, interrupt, counting and watchdog.
   Assumes the host bus model and a prescaler width of 3 (tick every 8 clocks). */
`timescale 1ns/100ps
`default_nettype none
module timer_application_modes_test;
   import timer_pkg::*;
   logic clock_in = 1'b0;
   logic rstn_in = 1'b0;
   logic timer_input_pin = 1'b0;
   logic timer_irq_ack_pin_n = 1'b1;
   logic [7:0] portc = 8'hA5;
   logic cs_n;
   logic rw;
   logic [RS_W-1:0] rs;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] data_out;
   logic data_oe;
   logic ack_n;
   logic timer_output_pin;
   logic timer_output_pin_oe;
   int miscompares = 0;
   int samples_checked = 0;
   int n;
   always #4 clock_in = ~clock_in;
   timer_application_modes #(.PRESCALE_W(3)) i_timer_application_modes (.clock_in(clock_in), .rstn_in(rstn_in),
      .cs_n_in(cs_n), .rw_in(rw), .rs_in(rs), .data_in(wdata), .data_out(data_out), .data_oe_out(data_oe),
      .bus_transfer_ack_n_out(ack_n), .timer_input_pin_in(timer_input_pin), .timer_irq_ack_pin_n_in(timer_irq_ack_pin_n),
      .timer_output_pin_out(timer_output_pin), .timer_output_pin_oe_out(timer_output_pin_oe), .portc_in(portc));
   host_bus_model i_host_bus_model (.clock_in(clock_in), .ack_n_in(ack_n), .rdata_in(data_out),
      .cs_n_out(cs_n), .rw_out(rw), .rs_out(rs), .wdata_out(wdata));
   // ==========================================
   // Compare, access and verdict tasks.
   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_bit(input string what, input logic exp, input logic got);
      check_byte(what, {7'h00, exp}, {7'h00, got});
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [7:0] x;
      i_host_bus_model.access(1'b0, a, d, x);
   endtask
   task automatic rd_check(input string what, input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] x;
      i_host_bus_model.access(1'b1, a, 8'h00, x);
      check_byte(what, exp, x);
   endtask
   task automatic wait_flag();
      logic [7:0] x;
      int k;
      k = 0;
      do begin
         i_host_bus_model.access(1'b1, RS_TIMER_STATUS, 8'h00, x);
         k++;
      end while (x[0] !== 1'b1 && k < 40);
      check_bit("flag", 1'b1, x[0]);
   endtask
   task automatic wait_out(input logic lvl, output int k);
      k = 0;
      do begin
         @(posedge clock_in);
         k++;
      end while (timer_output_pin !== lvl && k < 300);
      check_bit("timer_output_pin", lvl, timer_output_pin);
   endtask
   task automatic timer_irq_ack_pin_probe(input logic hit, input logic [7:0] vec);
      @(posedge clock_in);
      timer_irq_ack_pin_n <= 1'b0;
      repeat (3) @(posedge clock_in);
      #1;
      check_bit("ack_n", ~hit, ack_n);
      check_bit("data_oe", hit, data_oe);
      if (hit) begin
         check_byte("vector", vec, data_out);
      end
      @(posedge clock_in);
      timer_irq_ack_pin_n <= 1'b1;
      repeat (3) @(posedge clock_in);
   endtask
   task automatic pulse_tin(input int k);
      repeat (k) begin
         @(posedge clock_in);
         timer_input_pin <= 1'b1;
         repeat (4) @(posedge clock_in);
         timer_input_pin <= 1'b0;
         repeat (4) @(posedge clock_in);
      end
   endtask
   task automatic report_and_stop();
      miscompares = miscompares + i_host_bus_model.timeouts;
      $display("Comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // ==========================================
   // Test sequence.
   initial begin
      repeat (4) @(posedge clock_in);
      rstn_in <= 1'b1;
      @(posedge clock_in);
      #1;
      check_bit("timer_output_pin_oe", 1'b0, timer_output_pin_oe);
      rd_check("control", RS_TIMER_CONTROL, 8'h00);
      rd_check("vector", RS_TIMER_VECTOR, 8'h0F);
      rd_check("portc", RS_PORTC_DATA, 8'hA5);
      rd_check("unmapped", 5'h1F, 8'h00);
      timer_irq_ack_pin_probe(1'b0, 8'h00);
      wr(RS_PRELOAD_LOW, 8'h02);
      wr(RS_TIMER_CONTROL, 8'h40);
      check_bit("timer_output_pin", 1'b1, timer_output_pin);
      check_bit("timer_output_pin_oe", 1'b1, timer_output_pin_oe);
      wr(RS_TIMER_CONTROL, 8'h41);
      wait_out(1'b0, n);
      rd_check("status", RS_TIMER_STATUS, 8'h01);
      rd_check("portc", RS_PORTC_DATA, 8'hA5);
      wait_out(1'b1, n);
      rd_check("portc", RS_PORTC_DATA, 8'hAD);
      wait_out(1'b0, n);
      wait_out(1'b1, n);
      check_byte("period", 8'h18, n[7:0]);
      timer_irq_ack_pin_probe(1'b0, 8'h00);
      wr(RS_TIMER_STATUS, 8'h01);
      rd_check("status", RS_TIMER_STATUS, 8'h00);
      wait_flag();
      check_bit("timer_output_pin", 1'b0, timer_output_pin);
      rd_check("status", RS_TIMER_STATUS, 8'h01);
      wr(RS_TIMER_VECTOR, 8'h5A);
      wr(RS_PRELOAD_LOW, 8'h04);
      wr(RS_TIMER_CONTROL, 8'hB0);
      wr(RS_TIMER_CONTROL, 8'hB1);
      timer_irq_ack_pin_probe(1'b0, 8'h00);
      wait_flag();
      check_bit("timer_output_pin", 1'b0, timer_output_pin);
      timer_irq_ack_pin_probe(1'b1, 8'h5A);
      repeat (16) @(posedge clock_in);
      wr(RS_TIMER_CONTROL, 8'hB0);
      rd_check("status", RS_TIMER_STATUS, 8'h00);
      rd_check("count_high", RS_COUNT_HIGH, 8'hFF);
      wr(RS_PRELOAD_LOW, 8'h10);
      wr(RS_TIMER_CONTROL, 8'h16);
      wr(RS_TIMER_CONTROL, 8'h17);
      pulse_tin(6);
      wr(RS_TIMER_CONTROL, 8'h16);
      rd_check("count_low", RS_COUNT_LOW, 8'h0B);
      pulse_tin(3);
      rd_check("count_low", RS_COUNT_LOW, 8'h0B);
      wr(RS_TIMER_CONTROL, 8'h15);
      pulse_tin(16);
      wr(RS_TIMER_CONTROL, 8'h14);
      rd_check("count_low", RS_COUNT_LOW, 8'h0F);
      wr(RS_PRELOAD_LOW, 8'h03);
      wr(RS_TIMER_CONTROL, 8'hB3);
      @(posedge clock_in);
      timer_input_pin <= 1'b1;
      repeat (16) @(posedge clock_in);
      timer_input_pin <= 1'b0;
      repeat (4) @(posedge clock_in);
      check_bit("timer_output_pin", 1'b1, timer_output_pin);
      rd_check("status", RS_TIMER_STATUS, 8'h00);
      @(posedge clock_in);
      timer_input_pin <= 1'b1;
      wait_flag();
      check_bit("timer_output_pin", 1'b0, timer_output_pin);
      repeat (16) @(posedge clock_in);
      rd_check("count_high", RS_COUNT_HIGH, 8'hFF);
      @(posedge clock_in);
      timer_input_pin <= 1'b0;
      repeat (4) @(posedge clock_in);
      #1;
      check_bit("timer_output_pin", 1'b1, timer_output_pin);
      rd_check("status", RS_TIMER_STATUS, 8'h00);
      report_and_stop();
   end
   initial begin
      #100000;
      miscompares++;
      report_and_stop();
   end
endmodule
`default_nettype wire
